//--- design/frc_ctrl.sv
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// What this block does
// - Triangular ramp with separate step count, step time, deviation for up and down.
// - Fast ramp enable bit makes the two parameter sets separate slopes.
// - Writing one to the start bit of integer/fraction register starts the ramp.
// - Output select 1111 with function 00011 shows ramp complete on output pin.
// - External step bit bypasses ramp clock; each trigger pulse steps once, except in interrupt mode 11, where it holds the ramp.
// - Interrupts are recognised on the trigger rising edge only.
// - Output select 1111 with function 00010 routes readback to output pin.
// - Interrupt mode 00 off, 01 interrupt and continue, 11 interrupt and stop.
// - Readback data only while a ramp is running or held.
// - Interrupt captures 37-bit word: 12-bit integer then 25-bit fraction.
// - Bits shift out on serial clock rising edge; controller samples falling.
// - With fast lock on, integer/fraction write starts divider1 times divider2 interval.
// - Fast lock dividers both come from clock register fields, bits 11:0 and 23:12.
// - Fast lock interval is not applied while a ramp runs.
// - Charge pump current is sixteen times higher during the interval.
// - Divider mode fast lock grounds first switch, joins second to pump.
// - Third-order sigma-delta, fixed 25-bit modulus, clocked every cycle.
module frc_ctrl (
  input  wire logic                          clock,
  input  wire logic                          sys_rst,
  input  wire logic [7:0]                    s_axi_awaddr,
  input  wire logic                          s_axi_awvalid,
  output logic                               s_axi_awready,
  input  wire logic [31:0]                   s_axi_wdata,
  input  wire logic [3:0]                    s_axi_wstrb,
  input  wire logic                          s_axi_wvalid,
  output logic                               s_axi_wready,
  output logic [1:0]                         s_axi_bresp,
  output logic                               s_axi_bvalid,
  input  wire logic                          s_axi_bready,
  input  wire logic [7:0]                    s_axi_araddr,
  input  wire logic                          s_axi_arvalid,
  output logic                               s_axi_arready,
  output logic [31:0]                        s_axi_rdata,
  output logic [1:0]                         s_axi_rresp,
  output logic                               s_axi_rvalid,
  input  wire logic                          s_axi_rready,
  input  wire logic                          trigger_pin,
  input  wire logic                          serial_clock,
  output logic                               multiplexed_output_pin,
  output logic [frc_pkg::INT_W-1:0]          div_int,
  output logic signed [3:0]                  sd_offset,
  output logic [4:0]                         cp_gain,
  output logic                               first_switch_pin,
  output logic                               second_switch_pin
);
  import frc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]        reg_frac, reg_intctl, reg_clock, reg_ramp;
  frc_slope_t         slope [2];
  frc_state_t         state;
  logic [WORD_W-1:0]  n_acc, rb_word, rb_shift;
  logic [STEP_W-1:0]  step_cnt;
  logic [TIMER_W-1:0] tick_cnt;
  logic [FL_W-1:0]    fl_cnt;
  logic               trig_q, sclk_q, ramp_done, rb_valid, rb_bit;
  logic [FRAC_W-1:0]  acc1, acc2, acc3;
  logic               c2_d, c3_d, c3_dd;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        old[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return old;
  endfunction

  function automatic logic [WORD_W-1:0] step_amt(input frc_slope_t s);
    return {{(WORD_W-DEV_W){1'b0}}, s.dev} << s.dev_exp;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic       wr_go, rd_go, start_wr;
  logic [1:0] wave, irq_mode, fl_mode;
  logic       fast_en, ext_step, ramp_active, fl_active, trig_rise, sclk_rise, step_tick;
  logic [3:0] mux_sel;
  logic [4:0] mux_func;
  frc_slope_t down_set;

  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_go         = s_axi_awready;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_go         = s_axi_arvalid && s_axi_arready;
  assign start_wr      = wr_go && s_axi_awaddr == ADDR_INTCTL && s_axi_wstrb[3] && s_axi_wdata[INTCTL_START];
  assign wave          = reg_ramp[1:0];
  assign fast_en       = reg_ramp[RAMP_FAST];
  assign ext_step      = reg_ramp[RAMP_EXT];
  assign irq_mode      = reg_ramp[RAMP_IRQ_LSB +: 2];
  assign fl_mode       = reg_clock[CLOCK_MODE_LSB +: 2];
  assign mux_sel       = reg_intctl[INTCTL_MUX_LSB +: 4];
  assign mux_func      = reg_clock[CLOCK_FUNC_LSB +: 5];
  assign ramp_active   = state != FRC_IDLE;
  assign fl_active     = fl_cnt != '0;
  assign trig_rise     = trigger_pin && !trig_q;
  assign sclk_rise     = serial_clock && !sclk_q;
  assign down_set      = fast_en ? slope[1] : slope[0];
  assign step_tick     = ext_step ? trig_rise : tick_cnt == '0;

  always_ff @(posedge clock) begin
    trig_q <= sys_rst ? 1'b0 : trigger_pin;
    sclk_q <= sys_rst ? 1'b0 : serial_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes; the start bit is an action and is never stored.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_frac   <= 32'h0000_0000;
      reg_intctl <= 32'h0000_0000;
      reg_clock  <= 32'h0000_0000;
      reg_ramp   <= 32'h0000_0000;
      slope[0]   <= '0;
      slope[1]   <= '0;
    end else if (wr_go) begin
      case (s_axi_awaddr)
        ADDR_FRAC:   reg_frac   <= merge(reg_frac, s_axi_wdata, s_axi_wstrb) & 32'h01FF_FFFF;
        ADDR_INTCTL: reg_intctl <= merge(reg_intctl, s_axi_wdata, s_axi_wstrb) & 32'h0000_FFFF;
        ADDR_CLOCK:  reg_clock  <= merge(reg_clock, s_axi_wdata, s_axi_wstrb) & 32'h7FFF_FFFF;
        ADDR_RAMP:   reg_ramp   <= merge(reg_ramp, s_axi_wdata, s_axi_wstrb) & 32'h0000_003F;
        ADDR_UPA:    slope[0][31:0] <= merge(slope[0][31:0], s_axi_wdata, s_axi_wstrb);
        ADDR_UPB:    slope[0][47:32] <= DEV_W'(merge({16'h0000, slope[0][47:32]}, s_axi_wdata, s_axi_wstrb));
        ADDR_DNA:    slope[1][31:0] <= merge(slope[1][31:0], s_axi_wdata, s_axi_wstrb);
        ADDR_DNB:    slope[1][47:32] <= DEV_W'(merge({16'h0000, slope[1][47:32]}, s_axi_wdata, s_axi_wstrb));
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (s_axi_awaddr <= ADDR_DNB && s_axi_awaddr[1:0] == 2'b00) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        ADDR_FRAC:   s_axi_rdata <= reg_frac;
        ADDR_INTCTL: s_axi_rdata <= reg_intctl;
        ADDR_CLOCK:  s_axi_rdata <= reg_clock;
        ADDR_RAMP:   s_axi_rdata <= reg_ramp;
        ADDR_UPA:    s_axi_rdata <= slope[0][31:0];
        ADDR_UPB:    s_axi_rdata <= {16'h0000, slope[0][47:32]};
        ADDR_DNA:    s_axi_rdata <= slope[1][31:0];
        ADDR_DNB:    s_axi_rdata <= {16'h0000, slope[1][47:32]};
        ADDR_STATUS: s_axi_rdata <= {step_cnt, 10'h000, state, rb_valid, ramp_done, fl_active, ramp_active};
        ADDR_RB_LO:  s_axi_rdata <= rb_word[31:0];
        ADDR_RB_HI:  s_axi_rdata <= {27'h000_0000, rb_word[WORD_W-1:32]};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ramp engine: up half on set 0, down half on the down set, repeat.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state     <= FRC_IDLE;
      n_acc     <= '0;
      step_cnt  <= '0;
      tick_cnt  <= '0;
      ramp_done <= 1'b0;
    end else if (start_wr) begin
      n_acc     <= {s_axi_wdata[INT_W-1:0], reg_frac[FRAC_W-1:0]};
      step_cnt  <= '0;
      tick_cnt  <= slope[0].timer;
      ramp_done <= 1'b0;
      state     <= (wave == WAVE_TRIANGLE) ? FRC_UP : FRC_IDLE;
    end else begin
      if (wr_go && s_axi_awaddr == ADDR_INTCTL) begin
        n_acc[WORD_W-1:FRAC_W] <= s_axi_wdata[INT_W-1:0];
      end
      ramp_done <= 1'b0;
      case (state)
        FRC_UP, FRC_DOWN: begin
          if (irq_mode == IRQ_STOP && trig_rise) begin
            state <= FRC_HOLD;
          end else if (step_tick) begin
            tick_cnt <= (state == FRC_UP) ? slope[0].timer : down_set.timer;
            if (state == FRC_UP) begin
              n_acc <= n_acc + step_amt(slope[0]);
              if (step_cnt + 16'h0001 >= slope[0].steps) begin
                step_cnt <= '0;
                state    <= FRC_DOWN;
                tick_cnt <= down_set.timer;
              end else begin
                step_cnt <= step_cnt + 16'h0001;
              end
            end else begin
              n_acc <= n_acc - step_amt(down_set);
              if (step_cnt + 16'h0001 >= down_set.steps) begin
                step_cnt  <= '0;
                ramp_done <= 1'b1;
                state     <= FRC_UP;
                tick_cnt  <= slope[0].timer;
              end else begin
                step_cnt <= step_cnt + 16'h0001;
              end
            end
          end else begin
            tick_cnt <= tick_cnt - 12'h001;
          end
        end
        FRC_HOLD: state <= FRC_HOLD;
        default: state <= FRC_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback capture on interrupt and serial shift-out.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rb_word  <= '0;
      rb_shift <= '0;
      rb_bit   <= 1'b0;
      rb_valid <= 1'b0;
    end else if (trig_rise && irq_mode != IRQ_OFF && ramp_active && state != FRC_HOLD) begin
      rb_word  <= n_acc;
      rb_shift <= n_acc;
      rb_bit   <= 1'b0;
      rb_valid <= 1'b1;
    end else begin
      if (start_wr) begin
        rb_valid <= 1'b0;
      end
      if (sclk_rise) begin
        rb_bit   <= rb_shift[WORD_W-1];
        rb_shift <= {rb_shift[WORD_W-2:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || mux_sel != MUX_SEL_DIGITAL) begin
      multiplexed_output_pin <= 1'b0;
    end else if (mux_func == FUNC_RAMP_DONE) begin
      multiplexed_output_pin <= ramp_done;
    end else if (mux_func == FUNC_READBACK) begin
      multiplexed_output_pin <= ramp_active && rb_bit;
    end else begin
      multiplexed_output_pin <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fast lock window counted in clock (PFD) cycles.
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      fl_cnt <= '0;
    end else if (ramp_active || (start_wr && wave == WAVE_TRIANGLE)) begin
      fl_cnt <= '0;
    end else if (wr_go && s_axi_awaddr == ADDR_INTCTL && fl_mode != FL_OFF) begin
      fl_cnt <= reg_clock[DIV_W-1:0] * reg_clock[CLOCK_DIV2_LSB +: DIV_W];
    end else if (fl_active) begin
      fl_cnt <= fl_cnt - 24'h00_0001;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cp_gain           <= 5'h01;
      first_switch_pin  <= 1'b0;
      second_switch_pin <= 1'b0;
    end else begin
      cp_gain           <= fl_active ? 5'(CP_BOOST) : 5'h01;
      first_switch_pin  <= fl_active && fl_mode == FL_DIVIDER;
      second_switch_pin <= fl_active && fl_mode == FL_DIVIDER;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cascade of three first-order accumulators, modulus two to the 25.
  logic [FRAC_W:0]  s1, s2, s3;
  logic signed [3:0] next_offset;

  assign s1 = {1'b0, acc1} + {1'b0, n_acc[FRAC_W-1:0]};
  assign s2 = {1'b0, acc2} + {1'b0, s1[FRAC_W-1:0]};
  assign s3 = {1'b0, acc3} + {1'b0, s2[FRAC_W-1:0]};
  assign next_offset = 4'(s1[FRAC_W]) + 4'(s2[FRAC_W]) - 4'(c2_d) + 4'(s3[FRAC_W]) - 4'({c3_d, 1'b0}) + 4'(c3_dd);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      acc1      <= '0;
      acc2      <= '0;
      acc3      <= '0;
      c2_d      <= 1'b0;
      c3_d      <= 1'b0;
      c3_dd     <= 1'b0;
      sd_offset <= 4'sh0;
      div_int   <= '0;
    end else begin
      acc1      <= s1[FRAC_W-1:0];
      acc2      <= s2[FRAC_W-1:0];
      acc3      <= s3[FRAC_W-1:0];
      c2_d      <= s2[FRAC_W];
      c3_d      <= s3[FRAC_W];
      c3_dd     <= c3_d;
      sd_offset <= next_offset;
      div_int   <= n_acc[WORD_W-1:FRAC_W];
    end
  end
endmodule // frc_ctrl
`default_nettype wire

//--- design/frc_pkg.sv
package frc_pkg;
  localparam int INT_W   = 12;
  localparam int FRAC_W  = 25;
  localparam int WORD_W  = INT_W + FRAC_W;
  localparam int STEP_W  = 16;
  localparam int TIMER_W = 12;
  localparam int DEV_W   = 16;
  localparam int EXP_W   = 4;
  localparam int DIV_W   = 12;
  localparam int FL_W    = 2 * DIV_W;
  localparam int CP_BOOST = 16;

  localparam logic [7:0] ADDR_FRAC   = 8'h00;
  localparam logic [7:0] ADDR_INTCTL = 8'h04;
  localparam logic [7:0] ADDR_CLOCK  = 8'h08;
  localparam logic [7:0] ADDR_RAMP   = 8'h0C;
  localparam logic [7:0] ADDR_UPA    = 8'h10;
  localparam logic [7:0] ADDR_UPB    = 8'h14;
  localparam logic [7:0] ADDR_DNA    = 8'h18;
  localparam logic [7:0] ADDR_DNB    = 8'h1C;
  localparam logic [7:0] ADDR_STATUS = 8'h20;
  localparam logic [7:0] ADDR_RB_LO  = 8'h24;
  localparam logic [7:0] ADDR_RB_HI  = 8'h28;

  localparam int INTCTL_MUX_LSB  = 12;
  localparam int INTCTL_START    = 31;
  localparam int CLOCK_DIV2_LSB  = 12;
  localparam int CLOCK_MODE_LSB  = 24;
  localparam int CLOCK_FUNC_LSB  = 26;
  localparam int RAMP_FAST       = 2;
  localparam int RAMP_EXT        = 3;
  localparam int RAMP_IRQ_LSB    = 4;
  localparam int SET_DEV_LSB     = 16;
  localparam int SET_EXP_LSB     = 12;

  localparam logic [1:0] WAVE_TRIANGLE  = 2'b01;
  localparam logic [3:0] MUX_SEL_DIGITAL = 4'b1111;
  localparam logic [4:0] FUNC_READBACK  = 5'b00010;
  localparam logic [4:0] FUNC_RAMP_DONE = 5'b00011;
  localparam logic [1:0] IRQ_OFF        = 2'b00;
  localparam logic [1:0] IRQ_CONTINUE   = 2'b01;
  localparam logic [1:0] IRQ_STOP       = 2'b11;
  localparam logic [1:0] FL_OFF         = 2'b00;
  localparam logic [1:0] FL_DIVIDER     = 2'b01;
  localparam logic [1:0] RESP_OKAY      = 2'b00;
  localparam logic [1:0] RESP_SLVERR    = 2'b10;

  typedef enum logic [1:0] {
    FRC_IDLE = 2'b00,
    FRC_UP   = 2'b01,
    FRC_DOWN = 2'b10,
    FRC_HOLD = 2'b11
  } frc_state_t;

  typedef struct packed {
    logic [DEV_W-1:0]   dev;
    logic [EXP_W-1:0]   dev_exp;
    logic [TIMER_W-1:0] timer;
    logic [STEP_W-1:0]  steps;
  } frc_slope_t;
endpackage

//--- tb/frc_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module frc_ctrl_sva
  import frc_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              sys_rst,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  input  wire logic              s_axi_awready,
  input  wire logic              s_axi_wvalid,
  input  wire logic              s_axi_wready,
  input  wire logic [1:0]        s_axi_bresp,
  input  wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  input  wire logic              s_axi_arready,
  input  wire logic [31:0]       s_axi_rdata,
  input  wire logic [1:0]        s_axi_rresp,
  input  wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              multiplexed_output_pin,
  input  wire logic [4:0]        cp_gain,
  input  wire logic signed [3:0] sd_offset,
  input  wire logic              first_switch_pin,
  input  wire logic              second_switch_pin
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);

  // Cycles since the last accepted write to the integer/fraction register, saturating at 7.
  logic [2:0] since_wr;
  always_ff @(posedge clock) begin
    if (sys_rst)
      since_wr <= 3'd7;
    else if (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && s_axi_awaddr == ADDR_INTCTL)
      since_wr <= 3'd0;
    else if (since_wr != 3'd7)
      since_wr <= since_wr + 3'd1;
  end

  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |->
    s_axi_awready && s_axi_wready ##1 s_axi_bvalid) else $error("write not answered");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |-> s_axi_arready ##1 s_axi_rvalid)
    else $error("read not answered");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_read: assert property (s_axi_arvalid && !s_axi_rvalid && s_axi_araddr > ADDR_RB_HI |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000) else $error("unmapped read accepted");
  a_unmapped_write: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
    s_axi_awaddr > ADDR_RB_HI |=> s_axi_bresp == RESP_SLVERR) else $error("unmapped write accepted");
  a_gain_levels: assert property (cp_gain == 5'd1 || cp_gain == 5'd16)
    else $error("pump gain not 1 or 16");
  a_switch_boost: assert property (first_switch_pin |-> second_switch_pin && cp_gain == 5'd16)
    else $error("switches closed outside boost");
  a_boost_cause: assert property ($rose(cp_gain == 5'd16) |-> since_wr < 3'd4)
    else $error("boost without divider write");
  a_sd_range: assert property (sd_offset >= -3 && sd_offset <= 4)
    else $error("modulator offset out of range");

  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_boost: cover property (first_switch_pin);
  c_pin: cover property ($rose(multiplexed_output_pin));
endmodule // frc_ctrl_sva

bind frc_ctrl frc_ctrl_sva frc_ctrl_sva_inst (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .multiplexed_output_pin, .cp_gain, .sd_offset, .first_switch_pin, .second_switch_pin);
`default_nettype wire

//--- tb/frc_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module frc_host_model (
  input  wire logic clock,
  input  wire logic multiplexed_output_pin,
  output var logic  trigger_pin,
  output var logic  serial_clock
);
  initial begin
    trigger_pin = 1'b0;
    serial_clock = 1'b0;
  end

  // The pulse stays high long enough for the synchronous edge detector.
  task automatic pulse_trigger();
    trigger_pin <= 1'b1;
    repeat (3) @(posedge clock);
    trigger_pin <= 1'b0;
    repeat (3) @(posedge clock);
  endtask

  // The serial clock only runs inside a frame and rests low between frames.
  task automatic read_word(output logic [36:0] w);
    for (int i = 36; i >= 0; i--) begin
      serial_clock <= 1'b1;
      repeat (4) @(posedge clock);
      serial_clock <= 1'b0;
      w[i] = multiplexed_output_pin;
      repeat (2) @(posedge clock);
    end
  endtask
endmodule // frc_host_model
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import frc_pkg::*;
  logic              clock = 1'b0, sys_rst = 1'b1, trigger_pin, serial_clock, multiplexed_output_pin;
  logic [7:0]        s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata;
  logic              s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic              s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic              s_axi_rvalid, first_switch_pin, second_switch_pin;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic [11:0]       div_int, int_v;
  logic [24:0]       frac_v;
  logic signed [3:0] sd_offset;
  logic [4:0]        cp_gain;
  int                failures = 0, checks = 0, boost_cycles = 0, switch_cycles = 0;

  always #25 clock = ~clock;

  frc_ctrl frc_ctrl_inst (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .trigger_pin, .serial_clock, .multiplexed_output_pin, .div_int, .sd_offset,
    .cp_gain, .first_switch_pin, .second_switch_pin);
  frc_host_model frc_host_model_inst (.clock, .multiplexed_output_pin, .trigger_pin, .serial_clock);

  always @(posedge clock) begin
    if (cp_gain === 5'd16) boost_cycles++;
    if (first_switch_pin === 1'b1 && second_switch_pin === 1'b1) switch_cycles++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // A short random wait before taking the answer makes the slave hold its response.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] want);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge clock); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    repeat ($urandom_range(0, 2)) @(posedge clock);
    s_axi_bready <= 1'b1;
    do @(posedge clock); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, want);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clock); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    repeat ($urandom_range(0, 2)) @(posedge clock);
    s_axi_rready <= 1'b1;
    do @(posedge clock); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  function automatic logic [31:0] ramp_word(input logic ext, input logic [1:0] irq);
    return {26'h0, irq, ext, 1'b1, WAVE_TRIANGLE};
  endfunction

  function automatic logic [31:0] clk_word(input logic [4:0] f, input logic [1:0] m, input logic [11:0] d1,
                                           input logic [11:0] d2);
    return {1'b0, f, m, d2, d1};
  endfunction

  // Four up steps of one against two down steps of two: equal totals, so each ramp ends on its start word.
  task automatic ramp_go(input logic [31:0] rw, input logic [31:0] cw);
    wr(ADDR_DNB, 32'h0000_0002, RESP_OKAY);
    wr(ADDR_DNA, 32'h0003_0002, RESP_OKAY);
    wr(ADDR_UPB, 32'h0000_0001, RESP_OKAY);
    wr(ADDR_UPA, 32'h0001_0004, RESP_OKAY);
    wr(ADDR_RAMP, rw, RESP_OKAY);
    wr(ADDR_CLOCK, cw, RESP_OKAY);
    wr(ADDR_FRAC, {7'h00, frac_v}, RESP_OKAY);
    boost_cycles = 0;
    wr(ADDR_INTCTL, {1'b1, 15'h0000, MUX_SEL_DIGITAL, int_v}, RESP_OKAY);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [36:0] w;
    logic [15:0] steps;
    logic [1:0]  irq_codes [3];
    int          d1, d2, n;
    irq_codes = '{IRQ_OFF, IRQ_CONTINUE, IRQ_STOP};
    void'($urandom(7));
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    check(cp_gain, 5'd1);
    rd(8'h40, d, r);
    check({r, d}, {RESP_SLVERR, 32'h0000_0000});
    wr(8'h40, 32'hFFFF_FFFF, RESP_SLVERR);
    wr(ADDR_RAMP, ramp_word(1'b1, IRQ_CONTINUE), RESP_OKAY);
    wr(ADDR_CLOCK, clk_word(FUNC_READBACK, FL_OFF, 12'd1, 12'd1), RESP_OKAY);
    wr(ADDR_INTCTL, {16'h0000, MUX_SEL_DIGITAL, 12'h000}, RESP_OKAY);
    frc_host_model_inst.pulse_trigger();
    rd(ADDR_STATUS, d, r);
    check({d[3], d[0], multiplexed_output_pin}, 3'b000);
    for (int m = 0; m < 3; m++) begin
      int_v = 12'($urandom);
      d1 = $urandom_range(1, 6);
      d2 = $urandom_range(1, 6);
      wr(ADDR_CLOCK, clk_word(5'd0, 2'(m), 12'(d1), 12'(d2)), RESP_OKAY);
      boost_cycles = 0;
      switch_cycles = 0;
      wr(ADDR_INTCTL, {20'h00000, int_v}, RESP_OKAY);
      repeat (60) @(posedge clock);
      check(boost_cycles, (m != 0) ? d1 * d2 : 0);
      check(switch_cycles, (m == 1) ? d1 * d2 : 0);
    end
    int_v = 12'($urandom);
    frac_v = 25'($urandom);
    ramp_go(ramp_word(1'b0, IRQ_OFF), clk_word(FUNC_RAMP_DONE, FL_DIVIDER, 12'd5, 12'd5));
    n = 0;
    while (multiplexed_output_pin !== 1'b1 && n++ < 200) @(posedge clock);
    check(multiplexed_output_pin, 1'b1);
    check(div_int, int_v);
    check(boost_cycles, 0);
    rd(ADDR_STATUS, d, r);
    check(d[0], 1'b1);
    foreach (irq_codes[k]) begin
      int_v = 12'($urandom);
      frac_v = 25'($urandom);
      ramp_go(ramp_word(1'b1, irq_codes[k]), clk_word(FUNC_READBACK, FL_OFF, 12'd1, 12'd1));
      frc_host_model_inst.pulse_trigger();
      rd(ADDR_STATUS, d, r);
      check(d[3], irq_codes[k] != IRQ_OFF);
      steps = d[31:16];
      if (irq_codes[k] != IRQ_OFF) begin
        frc_host_model_inst.read_word(w);
        check(w, {int_v, frac_v});
      end
      frc_host_model_inst.pulse_trigger();
      rd(ADDR_STATUS, d, r);
      check(d[31:16], steps + ((irq_codes[k] == IRQ_STOP) ? 16'd0 : 16'd1));
      if (irq_codes[k] == IRQ_STOP) check(d[5:4], FRC_HOLD);
    end
    report_and_stop();
  end

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    report_and_stop();
  end
endmodule // testbench
`default_nettype wire
